// file: logic/battery_level_led_and_key_ui.sv
// Contract
// - display adapts to three, four, five LEDs
// - five LEDs: bands 80/60/40/20 percent
// - four LEDs: bands 75/50/25 percent
// - three LEDs: bands 66/33 percent
// - 1-5% first flickers, 0% all off
// - charging: lower steady, current band flickers
// - low power: five flickers, boost held off
// - fast-charge pin high on any fast state
// - key gives short, long, double presses
// - short press: ports and display on
// - long press toggles flash light
// - double press: ports and display off
// - grounded select pin chooses bus mode
// - bus slave at 100k or 400k
// - address 0x3C, pointer byte then data
// - flash and auth data exclusive
`timescale 1ns/1ps
module battery_level_led_and_key_ui #(
	parameter int FLICK_HALF_CYC = ui_pkg::FLICK_HALF_CYC,
	parameter int LONG_CYC       = ui_pkg::LONG_CYC,
	parameter int DBL_CYC        = ui_pkg::DBL_GAP_CYC,
	parameter int DEB_CYC        = ui_pkg::DEBOUNCE_CYC,
	parameter bit AUTH_DATA_EN   = 1'b0
) (
	input  wire logic       ref_clk,
	input  wire logic       arst_n,
	input  wire logic [6:0] capacity_pct,
	input  wire logic       charging,
	input  wire logic       low_power,
	input  wire logic       in_fast,
	input  wire logic       out_fast,
	input  wire logic [2:0] led_count,
	input  wire logic       fourth_indicator_bus_select_pin,
	input  wire logic       key_n,
	input  wire logic       auth_data_out,
	input  wire logic [4:0] ind_i,
	output logic      [4:0] ind_o,
	output logic      [4:0] ind_oe,
	output logic            fast_charge_indicator_pin,
	output logic            flash_or_auth_data_pin,
	output logic            port_a_en,
	output logic            port_c_en,
	output logic            boost_en
);

	// ------------------------------------------------------------
	// declarations
	// ------------------------------------------------------------
	logic        strap_done_reg, bus_mode_reg;
	logic [31:0] flk_cnt_reg;
	logic        blink_reg;
	logic        low_q_reg, lb_active_reg;
	logic [3:0]  lb_cnt_reg;
	logic        disp_en_reg, flash_light_driver_reg;
	logic [4:0]  led_reg, led_oe_reg;
	logic        short_key, long_key, double_key;
	logic        sda_oe, wr_stb;
	logic [7:0]  reg_addr, wr_data, rd_data;

	// ------------------------------------------------------------
	// key decoder and bus slave
	// ------------------------------------------------------------
	// timing from parameters
	key_press_decoder #(
		.DEB_CYC  (DEB_CYC),
		.LONG_CYC (LONG_CYC),
		.DBL_CYC  (DBL_CYC)
	) u_key (
		.ref_clk    (ref_clk),
		.arst_n     (arst_n),
		.key_n      (key_n),
		.short_key  (short_key),
		.long_key   (long_key),
		.double_key (double_key)
	);

	bus_reg_slave #(
		.DEV_ADDR (ui_pkg::BUS_ADDR)
	) u_bus (
		.ref_clk  (ref_clk),
		.arst_n   (arst_n),
		.enable   (bus_mode_reg),
		.scl      (ind_i[ui_pkg::PIN_SCL]),
		.sda_i    (ind_i[ui_pkg::PIN_SDA]),
		.sda_oe   (sda_oe),
		.reg_addr (reg_addr),
		.wr_stb   (wr_stb),
		.wr_data  (wr_data),
		.rd_data  (rd_data)
	);

	// ------------------------------------------------------------
	// capacity band decode
	// ------------------------------------------------------------
	wire n3 = (led_count == ui_pkg::N_LED3);
	wire n4 = (led_count == ui_pkg::N_LED4);
	wire [4:0] fit_mask = n3 ? ui_pkg::MASK3 : (n4 ? ui_pkg::MASK4 : ui_pkg::MASK5);
	wire [6:0] t1 = n3 ? ui_pkg::T3_1 : (n4 ? ui_pkg::T4_1 : ui_pkg::T5_1);
	wire [6:0] t2 = n3 ? ui_pkg::T3_2 : (n4 ? ui_pkg::T4_2 : ui_pkg::T5_2);
	wire [6:0] t3 = n3 ? ui_pkg::T_NONE : (n4 ? ui_pkg::T4_3 : ui_pkg::T5_3);
	wire [6:0] t4 = (n3 | n4) ? ui_pkg::T_NONE : ui_pkg::T5_4;
	// strict compare, boundary is lower band
	wire [2:0] above = 3'(capacity_pct > t1) + 3'(capacity_pct > t2)
		+ 3'(capacity_pct > t3) + 3'(capacity_pct > t4);
	wire [2:0] lit_dis = above + 3'h1;

	// ------------------------------------------------------------
	// pattern selection
	// ------------------------------------------------------------
	wire [4:0] on_dis  = 5'((6'h01 << lit_dis) - 6'h01);
	wire [4:0] on_chg  = 5'((6'h01 << above) - 6'h01);
	wire [4:0] flk_chg = blink_reg ? 5'(6'h01 << above) : 5'h00;
	wire [4:0] pat_dis = (capacity_pct == 7'h00) ? 5'h00
		: (capacity_pct <= ui_pkg::FLICK_MAX) ? {4'h0, blink_reg} : on_dis;
	wire [4:0] pat_chg = (capacity_pct >= ui_pkg::FULL_PCT) ? fit_mask
		: (on_chg | flk_chg);
	// low-power burst: on during even phases only
	wire [4:0] pat_lb  = {4'h0, ~lb_cnt_reg[0]};
	wire       led_show = disp_en_reg | charging;
	wire [4:0] pat = lb_active_reg ? pat_lb
		: (!led_show ? 5'h00 : (charging ? pat_chg : pat_dis));
	wire       first_level_indicator = pat[0];

	// ------------------------------------------------------------
	// strap capture
	// ------------------------------------------------------------
	// pin sampled once after reset release
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			strap_done_reg <= 1'b0;
			bus_mode_reg   <= 1'b0;
		end else if (!strap_done_reg) begin
			strap_done_reg <= 1'b1;
			bus_mode_reg   <= ~fourth_indicator_bus_select_pin;
		end
	end

	// ------------------------------------------------------------
	// flicker time base
	// ------------------------------------------------------------
	wire flk_tick = (flk_cnt_reg >= 32'(FLICK_HALF_CYC - 1));

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			flk_cnt_reg <= 32'h0;
			blink_reg   <= 1'b0;
		end else begin
			flk_cnt_reg <= flk_tick ? 32'h0 : flk_cnt_reg + 32'h1;
			if (flk_tick) blink_reg <= ~blink_reg;
		end
	end

	// ------------------------------------------------------------
	// low-power indication
	// ------------------------------------------------------------
	// a short press while low restarts the burst, so the user sees why
	wire lb_start = low_power & (~low_q_reg | short_key);

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			low_q_reg     <= 1'b0;
			lb_active_reg <= 1'b0;
			lb_cnt_reg    <= 4'h0;
		end else begin
			low_q_reg <= low_power;
			if (lb_start) begin
				lb_active_reg <= 1'b1;
				lb_cnt_reg    <= 4'h0;
			end else if (lb_active_reg && flk_tick) begin
				lb_cnt_reg <= lb_cnt_reg + 4'h1;
				if (lb_cnt_reg == ui_pkg::LB_PHASES - 4'h1) lb_active_reg <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// key actions and bus writes
	// ------------------------------------------------------------
	wire ctrl_wr = wr_stb & (reg_addr == ui_pkg::REG_CTRL);

	// key events take priority over a bus write in the same cycle
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			port_a_en              <= 1'b0;
			port_c_en              <= 1'b0;
			disp_en_reg            <= 1'b0;
			flash_light_driver_reg <= 1'b0;
		end else begin
			if (short_key) begin
				port_a_en   <= 1'b1;
				port_c_en   <= 1'b1;
				disp_en_reg <= 1'b1;
			end else if (double_key) begin
				port_a_en   <= 1'b0;
				port_c_en   <= 1'b0;
				disp_en_reg <= 1'b0;
			end else if (ctrl_wr) begin
				disp_en_reg <= wr_data[ui_pkg::CTRL_DISP];
			end
			if (long_key && !AUTH_DATA_EN) begin
				flash_light_driver_reg <= ~flash_light_driver_reg;
			end
		end
	end

	assign rd_data = (reg_addr == ui_pkg::REG_CTRL)
		? {4'h0, flash_light_driver_reg, disp_en_reg, port_c_en, port_a_en}
		: (reg_addr == ui_pkg::REG_LEVEL) ? {1'b0, capacity_pct} : 8'h00;

	// ------------------------------------------------------------
	// pin drivers
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			led_reg                   <= 5'h00;
			led_oe_reg                <= 5'h00;
			fast_charge_indicator_pin <= 1'b0;
			flash_or_auth_data_pin    <= 1'b0;
			boost_en                  <= 1'b0;
		end else begin
			led_reg    <= pat & fit_mask;
			led_oe_reg <= strap_done_reg ? fit_mask : 5'h00;
			fast_charge_indicator_pin <= in_fast | out_fast;
			flash_or_auth_data_pin <= AUTH_DATA_EN ? auth_data_out : flash_light_driver_reg;
			boost_en <= (port_a_en | port_c_en) & ~low_power;
		end
	end

	assign ind_o  = bus_mode_reg ? 5'h00 : led_reg;
	assign ind_oe = bus_mode_reg ? (5'(sda_oe) << ui_pkg::PIN_SDA) : led_oe_reg;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	wire dis_view = !bus_mode_reg && strap_done_reg && disp_en_reg
		&& !charging && !lb_active_reg && !lb_start;

	property p_fast_pin;
		@(posedge ref_clk) disable iff (!arst_n)
		(in_fast | out_fast) |=> fast_charge_indicator_pin;
	endproperty
	a_fast_pin: assert property (p_fast_pin) else $error("fast pin not high");

	property p_fast_off;
		@(posedge ref_clk) disable iff (!arst_n)
		!(in_fast | out_fast) |=> !fast_charge_indicator_pin;
	endproperty
	a_fast_off: assert property (p_fast_off) else $error("fast pin high");

	property p_empty_off;
		@(posedge ref_clk) disable iff (!arst_n)
		dis_view && capacity_pct == 7'h00 |=> ind_o == 5'h00;
	endproperty
	a_empty_off: assert property (p_empty_off) else $error("leds lit when empty");

	property p_full5;
		@(posedge ref_clk) disable iff (!arst_n)
		dis_view && led_count == 3'h5 && capacity_pct > 7'h50 |=> ind_o == 5'h1F;
	endproperty
	a_full5: assert property (p_full5) else $error("top band not all on");

	property p_edge80;
		@(posedge ref_clk) disable iff (!arst_n)
		dis_view && led_count == 3'h5 && capacity_pct == 7'h50 |=> ind_o == 5'h0F;
	endproperty
	a_edge80: assert property (p_edge80) else $error("boundary not lower band");

	property p_three_mid;
		@(posedge ref_clk) disable iff (!arst_n)
		dis_view && led_count == 3'h3 && capacity_pct == 7'h32 |=> ind_o == 5'h03;
	endproperty
	a_three_mid: assert property (p_three_mid) else $error("three led band wrong");

	property p_chg_full;
		@(posedge ref_clk) disable iff (!arst_n)
		!bus_mode_reg && strap_done_reg && charging && !lb_active_reg && !lb_start
		&& led_count == 3'h4 && capacity_pct == 7'h64 |=> ind_o == 5'h0F;
	endproperty
	a_chg_full: assert property (p_chg_full) else $error("full charge not steady");

	sequence s_short;
		short_key && !low_power;
	endsequence
	sequence s_ports_on;
		port_a_en && port_c_en && disp_en_reg ##1 boost_en;
	endsequence
	property p_short_on;
		@(posedge ref_clk) disable iff (!arst_n)
		s_short ##1 !low_power |-> s_ports_on;
	endproperty
	a_short_on: assert property (p_short_on) else $error("short press ignored");

	property p_double_off;
		@(posedge ref_clk) disable iff (!arst_n)
		double_key && !short_key |=> !port_a_en && !port_c_en && !disp_en_reg;
	endproperty
	a_double_off: assert property (p_double_off) else $error("double press ignored");

	property p_long_flip;
		@(posedge ref_clk) disable iff (!arst_n)
		long_key && !AUTH_DATA_EN |=> flash_light_driver_reg != $past(flash_light_driver_reg);
	endproperty
	a_long_flip: assert property (p_long_flip) else $error("flash not toggled");

	property p_low_boost;
		@(posedge ref_clk) disable iff (!arst_n)
		low_power |=> !boost_en;
	endproperty
	a_low_boost: assert property (p_low_boost) else $error("boost on while low");

	property p_lb_first;
		@(posedge ref_clk) disable iff (!arst_n)
		lb_start |=> lb_active_reg && lb_cnt_reg == 4'h0 && first_level_indicator;
	endproperty
	a_lb_first: assert property (p_lb_first) else $error("burst did not start");

	property p_bus_pins;
		@(posedge ref_clk) disable iff (!arst_n)
		bus_mode_reg |-> ind_o == 5'h00 && ind_oe[ui_pkg::PIN_SCL] == 1'b0;
	endproperty
	a_bus_pins: assert property (p_bus_pins) else $error("led drive in bus mode");

endmodule // battery_level_led_and_key_ui

// file: logic/bus_reg_slave.sv
`timescale 1ns/1ps
module bus_reg_slave #(
	parameter logic [6:0] DEV_ADDR = 7'h3C
) (
	input  wire logic       ref_clk,
	input  wire logic       arst_n,
	input  wire logic       enable,
	input  wire logic       scl,
	input  wire logic       sda_i,
	output logic            sda_oe,
	output logic [7:0]      reg_addr,
	output logic            wr_stb,
	output logic [7:0]      wr_data,
	input  wire logic [7:0] rd_data
);

	typedef enum logic [4:0] {
		B_IDLE = 5'h01,
		B_RX   = 5'h02,
		B_ACK  = 5'h04,
		B_TX   = 5'h08,
		B_RACK = 5'h10
	} bus_state_t;

	bus_state_t state_reg;
	logic [7:0] sh_reg;
	logic [3:0] cnt_reg;
	logic [1:0] byte_reg;
	logic       rw_reg, scl_q, sda_q;

	// ------------------------------------------------------------
	// line events, oversampled; fine at both bus rates
	// ------------------------------------------------------------
	wire scl_rise = scl & ~scl_q;
	wire scl_fall = ~scl & scl_q;
	wire start_ev = enable & scl & scl_q & sda_q & ~sda_i;
	wire stop_ev  = enable & scl & scl_q & ~sda_q & sda_i;
	wire addr_hit = (sh_reg[7:1] == DEV_ADDR);

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			state_reg <= B_IDLE;
			sh_reg    <= 8'h00;
			cnt_reg   <= 4'h0;
			byte_reg  <= 2'h0;
			rw_reg    <= 1'b0;
			scl_q     <= 1'b1;
			sda_q     <= 1'b1;
			sda_oe    <= 1'b0;
			reg_addr  <= 8'h00;
			wr_stb    <= 1'b0;
			wr_data   <= 8'h00;
		end else begin
			scl_q  <= scl;
			sda_q  <= sda_i;
			wr_stb <= 1'b0;
			if (!enable || stop_ev) begin
				state_reg <= B_IDLE;
				sda_oe    <= 1'b0;
			end else if (start_ev) begin
				state_reg <= B_RX;
				cnt_reg   <= 4'h0;
				byte_reg  <= 2'h0;
				sda_oe    <= 1'b0;
			end else begin
				case (state_reg)
					B_RX: begin
						if (scl_rise) begin
							sh_reg  <= {sh_reg[6:0], sda_i};
							cnt_reg <= cnt_reg + 4'h1;
						end else if (scl_fall && cnt_reg == 4'h8) begin
							cnt_reg <= 4'h0;
							if (byte_reg == 2'h0) begin
								rw_reg    <= sh_reg[0];
								sda_oe    <= addr_hit;
								state_reg <= addr_hit ? B_ACK : B_IDLE;
							end else begin
								if (byte_reg == 2'h1) begin
									reg_addr <= sh_reg;
								end else begin
									wr_data <= sh_reg;
									wr_stb  <= 1'b1;
								end
								sda_oe    <= 1'b1;
								state_reg <= B_ACK;
							end
						end
					end
					B_ACK: begin
						if (scl_fall) begin
							if (byte_reg != 2'h3) byte_reg <= byte_reg + 2'h1;
							if (byte_reg >= 2'h2) reg_addr <= reg_addr + 8'h01;
							if (rw_reg && byte_reg == 2'h0) begin
								sh_reg    <= {rd_data[6:0], 1'b0};
								sda_oe    <= ~rd_data[7];
								cnt_reg   <= 4'h1;
								state_reg <= B_TX;
							end else begin
								sda_oe    <= 1'b0;
								state_reg <= B_RX;
							end
						end
					end
					B_TX: begin
						if (scl_fall) begin
							if (cnt_reg == 4'h8) begin
								sda_oe    <= 1'b0;
								reg_addr  <= reg_addr + 8'h01;
								state_reg <= B_RACK;
							end else begin
								sda_oe  <= ~sh_reg[7];
								sh_reg  <= {sh_reg[6:0], 1'b0};
								cnt_reg <= cnt_reg + 4'h1;
							end
						end
					end
					B_RACK: begin
						// a not-acknowledge from the host ends the read
						if (scl_rise && sda_i) begin
							state_reg <= B_IDLE;
						end else if (scl_fall) begin
							sh_reg    <= {rd_data[6:0], 1'b0};
							sda_oe    <= ~rd_data[7];
							cnt_reg   <= 4'h1;
							state_reg <= B_TX;
						end
					end
					default: sda_oe <= 1'b0;
				endcase
			end
		end
	end

endmodule // bus_reg_slave

// file: logic/key_press_decoder.sv
`timescale 1ns/1ps
module key_press_decoder #(
	parameter int DEB_CYC  = 16,
	parameter int LONG_CYC = 1024,
	parameter int DBL_CYC  = 256
) (
	input  wire logic ref_clk,
	input  wire logic arst_n,
	input  wire logic key_n,
	output logic      short_key,
	output logic      long_key,
	output logic      double_key
);

	typedef enum logic [4:0] {
		K_IDLE   = 5'h01,
		K_PRESS  = 5'h02,
		K_GAP    = 5'h04,
		K_PRESS2 = 5'h08,
		K_HOLD   = 5'h10
	} key_state_t;

	key_state_t  state_reg, state_next;
	logic [31:0] cnt_reg, cnt_next;
	logic        sp_next, lp_next, dp_next;
	wire         pressed = ~key_n;

	// ------------------------------------------------------------
	// press classifier
	// ------------------------------------------------------------
	// three event kinds
	always_comb begin
		state_next = state_reg;
		cnt_next   = cnt_reg + 32'h1;
		sp_next    = 1'b0;
		lp_next    = 1'b0;
		dp_next    = 1'b0;
		case (state_reg)
			K_IDLE: begin
				cnt_next = 32'h0;
				if (pressed) state_next = K_PRESS;
			end
			K_PRESS: begin
				// bounces shorter than the debounce time are dropped
				if (!pressed) begin
					cnt_next   = 32'h0;
					state_next = (cnt_reg >= 32'(DEB_CYC)) ? K_GAP : K_IDLE;
				end else if (cnt_reg >= 32'(LONG_CYC)) begin
					lp_next    = 1'b1;
					state_next = K_HOLD;
				end
			end
			K_GAP: begin
				// a short press is only known once the gap has passed
				if (pressed) begin
					cnt_next   = 32'h0;
					state_next = K_PRESS2;
				end else if (cnt_reg >= 32'(DBL_CYC)) begin
					sp_next    = 1'b1;
					state_next = K_IDLE;
				end
			end
			K_PRESS2: begin
				if (!pressed) begin
					dp_next    = 1'b1;
					state_next = K_IDLE;
				end
			end
			K_HOLD: begin
				if (!pressed) state_next = K_IDLE;
			end
			default: state_next = K_IDLE;
		endcase
	end

	// state and one-cycle event pulses
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			state_reg  <= K_IDLE;
			cnt_reg    <= 32'h0;
			short_key  <= 1'b0;
			long_key   <= 1'b0;
			double_key <= 1'b0;
		end else begin
			state_reg  <= state_next;
			cnt_reg    <= cnt_next;
			short_key  <= sp_next;
			long_key   <= lp_next;
			double_key <= dp_next;
		end
	end

endmodule // key_press_decoder

// file: logic/ui_pkg.sv
package ui_pkg;

	// ------------------------------------------------------------
	// clock and timing
	// ------------------------------------------------------------
	localparam int CLK_KHZ        = 250_000;
	localparam int FLICK_HALF_MS  = 250;
	localparam int LONG_MS        = 2000;
	localparam int DBL_GAP_MS     = 300;
	localparam int DEBOUNCE_MS    = 20;
	localparam int FLICK_HALF_CYC = FLICK_HALF_MS * CLK_KHZ;
	localparam int LONG_CYC       = LONG_MS * CLK_KHZ;
	localparam int DBL_GAP_CYC    = DBL_GAP_MS * CLK_KHZ;
	localparam int DEBOUNCE_CYC   = DEBOUNCE_MS * CLK_KHZ;

	// ------------------------------------------------------------
	// capacity bands, in percent
	// ------------------------------------------------------------
	localparam logic [6:0] T5_1     = 7'h14;
	localparam logic [6:0] T5_2     = 7'h28;
	localparam logic [6:0] T5_3     = 7'h3C;
	localparam logic [6:0] T5_4     = 7'h50;
	localparam logic [6:0] T4_1     = 7'h19;
	localparam logic [6:0] T4_2     = 7'h32;
	localparam logic [6:0] T4_3     = 7'h4B;
	localparam logic [6:0] T3_1     = 7'h21;
	localparam logic [6:0] T3_2     = 7'h42;
	localparam logic [6:0] T_NONE   = 7'h7F;
	localparam logic [6:0] FLICK_MAX = 7'h05;
	localparam logic [6:0] FULL_PCT = 7'h64;
	localparam logic [2:0] N_LED3   = 3'h3;
	localparam logic [2:0] N_LED4   = 3'h4;
	localparam logic [4:0] MASK3    = 5'h07;
	localparam logic [4:0] MASK4    = 5'h0F;
	localparam logic [4:0] MASK5    = 5'h1F;
	localparam logic [3:0] LB_PHASES = 4'hA;

	// ------------------------------------------------------------
	// bus slave and its registers
	// ------------------------------------------------------------
	localparam logic [6:0] BUS_ADDR  = 7'h3C;
	localparam logic [7:0] REG_CTRL  = 8'h00;
	localparam logic [7:0] REG_LEVEL = 8'h01;
	localparam int CTRL_DISP = 0;
	localparam int PIN_SCL   = 1;
	localparam int PIN_SDA   = 2;

endpackage

// file: tb/test_battery_level_led_and_key_ui.sv
`timescale 1ns/1ps
module test_battery_level_led_and_key_ui;
	logic       ref_clk      = 1'b0;
	logic       arst_n       = 1'b0;
	logic [6:0] capacity_pct = 7'h00;
	logic       charging     = 1'b0;
	logic       low_power    = 1'b0;
	logic       in_fast      = 1'b0;
	logic       out_fast     = 1'b0;
	logic [2:0] led_count    = 3'h5;
	logic       fourth_indicator_bus_select_pin = 1'b1;
	logic       auth_data_out = 1'b0;
	logic [7:0] rd;
	logic       ack_n;
	logic [4:0] ind_i, ind_o, ind_oe, lit_and, lit_or;
	logic       key_n, fast_charge_indicator_pin, flash_or_auth_data_pin;
	logic       port_a_en, port_c_en, boost_en;
	int         fail_count  = 0;
	int         comparisons = 0;
	int         rises;
	// LED count, percent, lamps expected while discharging
	logic [14:0] rows [19] = '{
		{3'h5, 7'h64, 5'h1F}, {3'h5, 7'h51, 5'h1F}, {3'h5, 7'h50, 5'h0F},
		{3'h5, 7'h3D, 5'h0F}, {3'h5, 7'h29, 5'h07}, {3'h5, 7'h15, 5'h03},
		{3'h5, 7'h14, 5'h01}, {3'h5, 7'h06, 5'h01}, {3'h5, 7'h00, 5'h00},
		{3'h4, 7'h4C, 5'h0F}, {3'h4, 7'h4B, 5'h07}, {3'h4, 7'h1A, 5'h03},
		{3'h4, 7'h19, 5'h01}, {3'h3, 7'h43, 5'h07}, {3'h3, 7'h42, 5'h03},
		{3'h3, 7'h22, 5'h03}, {3'h3, 7'h21, 5'h01}, {3'h3, 7'h00, 5'h00},
		{3'h3, 7'h32, 5'h03}};

	always #2 ref_clk = ~ref_clk;

	battery_level_led_and_key_ui #(.FLICK_HALF_CYC(8), .LONG_CYC(200), .DBL_CYC(60),
		.DEB_CYC(4)) i_battery_level_led_and_key_ui (.ref_clk, .arst_n, .capacity_pct,
		.charging, .low_power, .in_fast, .out_fast, .led_count,
		// strap starts high for the lamps and is grounded later for the bus
		.fourth_indicator_bus_select_pin, .key_n, .auth_data_out, .ind_i,
		.ind_o, .ind_oe, .fast_charge_indicator_pin, .flash_or_auth_data_pin,
		.port_a_en, .port_c_en, .boost_en);

	ui_far_side i_ui_far_side (.ref_clk, .ind_o, .ind_oe, .ind_i, .key_n);

	task automatic chk(input logic [4:0] got, input logic [4:0] exp);
		comparisons++;
		if (got !== exp) begin
			fail_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			fail_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask

	// watch the lamps: steady-on bits, ever-on bits, first lamp rises
	task automatic watch(input int n);
		lit_and = 5'h1F;
		lit_or  = 5'h00;
		rises   = 0;
		repeat (n) begin
			logic prev;
			prev = ind_o[0];
			cyc(1);
			lit_and &= ind_o;
			lit_or  |= ind_o;
			rises   += int'(ind_o[0] & ~prev);
		end
	endtask

	task automatic conclude;
		$display("comparisons %0d, mismatches %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// watchdog: the whole sequence needs well under 3000 cycles
	initial begin
		cyc(6000);
		fail_count++;
		conclude();
	end

	initial begin
		cyc(1);
		chk(ind_oe, 5'h00);
		chk({1'b0, port_a_en, port_c_en, boost_en, flash_or_auth_data_pin}, 5'h00);
		cyc(11);
		arst_n = 1'b1;
		cyc(3);
		chk(ind_oe, 5'h1F);
		$display("reset test done");
		// short press switches ports and display on
		i_ui_far_side.press(10);
		cyc(80);
		chk({2'h0, port_a_en, port_c_en, boost_en}, 5'h07);
		foreach (rows[i]) begin
			{led_count, capacity_pct} = rows[i][14:5];
			cyc(3);
			chk(ind_o, rows[i][4:0]);
			chk(ind_oe, 5'((6'h01 << led_count) - 6'h01));
		end
		$display("capacity table done");
		led_count    = 3'h5;
		capacity_pct = 7'h03;
		watch(40);
		chk(lit_and | lit_or, 5'h01);
		chk(5'(rises > 1), 5'h01);
		charging     = 1'b1;
		capacity_pct = 7'h32;
		cyc(2);
		watch(40);
		chk(lit_and, 5'h03);
		chk(lit_or, 5'h07);
		// full charge on four lamps: every fitted lamp steady, the fifth dark
		led_count    = 3'h4;
		capacity_pct = 7'h64;
		cyc(2);
		watch(20);
		chk(lit_and, 5'h0F);
		chk(lit_or, 5'h0F);
		$display("flicker test done");
		// burst starts from an empty display so each flash is one rise
		charging     = 1'b0;
		capacity_pct = 7'h00;
		cyc(3);
		low_power = 1'b1;
		watch(150);
		chk(5'(rises), 5'h05);
		chk(lit_or, 5'h01);
		chk(5'(boost_en), 5'h00);
		low_power = 1'b0;
		$display("low power test done");
		for (int f = 0; f < 4; f++) begin
			{in_fast, out_fast} = 2'(f);
			cyc(2);
			chk(5'(fast_charge_indicator_pin), 5'(f != 0));
		end
		// auth data must not reach the shared pin while the flash owns it
		auth_data_out = 1'b1;
		for (int k = 0; k < 2; k++) begin
			i_ui_far_side.press(220);
			cyc(80);
			chk(5'(flash_or_auth_data_pin), 5'(k == 0));
		end
		capacity_pct = 7'h32;
		i_ui_far_side.press(10);
		cyc(20);
		i_ui_far_side.press(10);
		cyc(6);
		chk({port_a_en, port_c_en, ind_o[2:0]}, 5'h00);
		$display("key test done");
		// second reset with the select pin grounded: shared pins become the bus
		fourth_indicator_bus_select_pin = 1'b0;
		arst_n = 1'b0;
		cyc(2);
		arst_n = 1'b1;
		cyc(3);
		chk(ind_oe | ind_o, 5'h00);
		// a foreign address is left unacknowledged
		i_ui_far_side.bus_start();
		i_ui_far_side.bus_byte(8'h7A, 1'b1, rd, ack_n);
		chk(5'(ack_n), 5'h01);
		i_ui_far_side.bus_stop();
		// write the display enable through the pointer
		i_ui_far_side.bus_start();
		i_ui_far_side.bus_byte(8'h78, 1'b1, rd, ack_n);
		chk(5'(ack_n), 5'h00);
		i_ui_far_side.bus_byte(ui_pkg::REG_CTRL, 1'b1, rd, ack_n);
		i_ui_far_side.bus_byte(8'h01, 1'b1, rd, ack_n);
		chk(5'(ack_n), 5'h00);
		i_ui_far_side.bus_stop();
		// read control and level back in one burst
		i_ui_far_side.bus_start();
		i_ui_far_side.bus_byte(8'h78, 1'b1, rd, ack_n);
		i_ui_far_side.bus_byte(ui_pkg::REG_CTRL, 1'b1, rd, ack_n);
		i_ui_far_side.bus_start();
		i_ui_far_side.bus_byte(8'h79, 1'b1, rd, ack_n);
		i_ui_far_side.bus_byte(8'hFF, 1'b0, rd, ack_n);
		chk_byte(rd, 8'h04);
		i_ui_far_side.bus_byte(8'hFF, 1'b1, rd, ack_n);
		chk_byte(rd, {1'b0, capacity_pct});
		i_ui_far_side.bus_stop();
		chk(ind_o, 5'h00);
		$display("bus test done");
		conclude();
	end
endmodule // test_battery_level_led_and_key_ui

// file: tb/ui_far_side.sv
`timescale 1ns/1ps
module ui_far_side (
	input  wire logic       ref_clk,
	input  wire logic [4:0] ind_o,
	input  wire logic [4:0] ind_oe,
	output logic      [4:0] ind_i,
	output logic            key_n
);
	logic scl_h = 1'b1;
	logic sda_h = 1'b1;

	// open-drain lines: pulled up, host and slave only pull low
	assign ind_i = ((ind_o & ind_oe) | ~ind_oe) & {2'b11, sda_h, scl_h, 1'b1};

	initial key_n = 1'b1;

	// a third of a bus clock (one bit takes three of these); lines move just after an edge
	task automatic quarter;
		repeat (4) @(posedge ref_clk);
		#1;
	endtask

	// start or repeated start: data falls while the clock is high
	task automatic bus_start;
		sda_h = 1'b1;
		quarter();
		scl_h = 1'b1;
		quarter();
		sda_h = 1'b0;
		quarter();
		scl_h = 1'b0;
	endtask

	// stop: data rises while the clock is high
	task automatic bus_stop;
		sda_h = 1'b0;
		quarter();
		scl_h = 1'b1;
		quarter();
		sda_h = 1'b1;
		quarter();
	endtask

	// one bit: data set while the clock is low, line read while it is high
	task automatic bus_bit(input logic b, output logic r);
		quarter();
		sda_h = b;
		quarter();
		scl_h = 1'b1;
		quarter();
		r     = ind_i[2];
		scl_h = 1'b0;
	endtask

	// a byte, then the ninth slot with the host's own level in it
	task automatic bus_byte(input logic [7:0] d, input logic ack_in, output logic [7:0] r,
			output logic ack_n);
		for (int i = 7; i >= 0; i--) bus_bit(d[i], r[i]);
		bus_bit(ack_in, ack_n);
	endtask

	// hold the key down for cyc cycles; changes land just after an edge
	task automatic press(input int cyc);
		@(posedge ref_clk) #1 key_n = 1'b0;
		repeat (cyc) @(posedge ref_clk);
		#1 key_n = 1'b1;
	endtask
endmodule // ui_far_side
